// [verilog/rsps_cfg.svh]
/*
  Constants of the read strobe phase-shift block: widths, counts, reset
  values and timing figures.
  Assumes inclusion by bare name from the package, every design module, the checker and the testbench.
*/
`ifndef RSPS_CFG_SVH
`define RSPS_CFG_SVH

// Core clock rate
`define RSPS_CLK_MHZ 50
// Delay setting width
`define RSPS_SET_W 7
// Largest binary setting
`define RSPS_SET_MAX 7'h7F
// Elements in the loop chain, each worth 45 degrees at lock
`define RSPS_DLL_ELEMS 8
// Elements in each strobe chain
`define RSPS_STROBE_ELEMS 4
// Shift register depth of one element: intrinsic plus 127 steps plus one
`define RSPS_TAP_DEPTH 129
// Intrinsic element delay in steps
`define RSPS_INTRINSIC_STEPS 8'h01
// Size of one delay step in core cycles
`define RSPS_STEP_SIZE 8'h01
// Lock waits in reference cycles
`define RSPS_LOCK_LOWJIT 12'hA00
`define RSPS_LOCK_NORMAL 12'h200
`define RSPS_LOCK_W 12
// Gray-code counter setting after loop reset (binary 127)
`define RSPS_DLL_INIT_GRAY 7'h40
// Clock edges between two update enable pulses
`define RSPS_UPD_EDGES 3'h4
// Largest element count usable under the loop (135 degrees)
`define RSPS_MAX_LOOP_ELEMS 3'h3
// Strobe units and strobe groups
`define RSPS_NSTROBE 2
`define RSPS_NGROUP 2
// Pins passed through synchronisers: ref, reset, user clock, strobes
`define RSPS_NSYNC 5

`endif

// [verilog/rsps_pkg.sv]
/*
  Types and code conversions of the read strobe phase-shift block.
  Assumes rsps_cfg.svh is on the include path.
*/
`include "rsps_cfg.svh"

package rsps_pkg;

  typedef logic [`RSPS_SET_W-1:0] rsps_set_t;

  // Loop state after a loop reset
  typedef enum logic [1:0] {
    DLL_RESET,
    DLL_WAIT,
    DLL_LOCKED
  } rsps_lock_e;

  // Loop-wide configuration
  typedef struct packed {
    logic low_jitter;
    logic use_core_settings;
    logic offset_enable;
    logic update_from_user;
  } rsps_dll_cfg_s;

  // Per strobe configuration and gate request
  typedef struct packed {
    logic bypass;
    logic [1:0] elem_count;
    logic half_rate_gate;
    logic gate_req;
  } rsps_strobe_cfg_s;

  // Gray code to binary
  function automatic rsps_set_t gray2bin(input rsps_set_t g);
    rsps_set_t b;
    b[`RSPS_SET_W-1] = g[`RSPS_SET_W-1];
    for (int i = `RSPS_SET_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Binary to Gray code
  function automatic rsps_set_t bin2gray(input rsps_set_t b);
    return b ^ (b >> 1);
  endfunction

endpackage

// [verilog/rsps_dly_elem.sv]
/*
  One programmable delay element, modelled as a shift register tapped at
  intrinsic delay plus steps times step size.
  Assumes steps in binary and a signal already in the core clock domain.
*/
`include "rsps_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rsps_dly_elem (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sig_in,
  input wire logic [`RSPS_SET_W-1:0] steps,
  output logic sig_out
);

  logic [`RSPS_TAP_DEPTH-1:0] line;
  logic [15:0] tap;

  // Delay line
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line <= '0;
    end else begin
      line <= {line[`RSPS_TAP_DEPTH-2:0], sig_in};
    end
  end

  // Intrinsic delay plus steps times step size [R13]
  assign tap = 16'(`RSPS_INTRINSIC_STEPS) +
               16'({1'b0, steps}) * 16'(`RSPS_STEP_SIZE);
  assign sig_out = line[tap[7:0]];

endmodule

`default_nettype wire

// [verilog/rsps_gray_cnt.sv]
/*
  Saturating 7-bit Gray-code up/down counter that holds the loop setting.
  Assumes step and up come from logic on core_clk.
*/
`include "rsps_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rsps_gray_cnt (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic step,
  input wire logic up,
  output rsps_pkg::rsps_set_t gray
);

  rsps_pkg::rsps_set_t bin;
  rsps_pkg::rsps_set_t next_gray;

  // Step one count, stop at either end
  always_comb begin
    bin = rsps_pkg::gray2bin(gray);
    next_gray = gray;
    if (step && up && bin != `RSPS_SET_MAX) begin
      next_gray = rsps_pkg::bin2gray(bin + 7'h01);
    end else if (step && !up && bin != 7'h00) begin
      next_gray = rsps_pkg::bin2gray(bin - 7'h01);
    end
  end

  // Counter register, back to its fixed start on loop reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gray <= `RSPS_DLL_INIT_GRAY;
    end else if (clear) begin
      gray <= `RSPS_DLL_INIT_GRAY; // [R25]
    end else begin
      gray <= next_gray; // [R02]
    end
  end

endmodule

`default_nettype wire

// [verilog/rsps_top.sv]
/*
  Read strobe phase-shift block: delay-locked loop, update enable, per
  strobe delay chains, postamble gating with half-rate stage, and per
  group leveling tap selection.
  Assumes pins arrive asynchronously and are sampled on core_clk; the
  reference, user and strobe signals are slow against core_clk.
*/
//
// Function
// R01 - Reference passes eight delay elements; output compared to reference.
// R02 - Comparator steps a 7-bit Gray setting up or down toward phase match.
// R03 - User waits 2,560 or 512 reference cycles after any loop reset.
// R04 - Loop input clock at least 300 MHz, multiplied for slower interfaces; here the reference is sampled on the 50 MHz core_clk, with no multiplier.
// R05 - Multiplied loop clock limits strobe shift to 67.5 or 33.75 degrees.
// R06 - Every strobe pin has its own delay, update and postamble logic; here one update enable and one set of settings registers serve all pins.
// R07 - Delay and offset settings registered, loaded only on update enable.
// R08 - Update enable derives from reference clock or core user clock.
// R09 - Strobe chain holds four elements matching the loop elements.
// R10 - First strobe element uses setting alone or setting plus offset.
// R11 - Strobe chains take settings from the loop or from core logic.
// R12 - Core may drive Gray 7-bit settings controlling one to four elements.
// R13 - Chain delay is intrinsic delay plus steps times step size.
// R14 - Strobe chain bypass gives zero-degree shift.
// R15 - Postamble registers force shifted strobe low at end of read.
// R16 - Memory drives strobe low in preamble and postamble.
// R17 - Half-rate gate stage clocked by half-rate resynchronization clock.
// R18 - Postamble register outputs ANDed to stop glitches on later bursts.
// R19 - Gate enable asserts with half-cycle latency, deasserts with none.
// R20 - Half-rate stage as first gate capture is optional.
// R21 - One leveling circuit per sub-bank, compensated by same settings.
// R22 - Loop gives eight taps of 45 degrees to every strobe unit; here the taps reach only the per-group leveling selection.
// R23 - Controller mux per strobe group selects one tap output.
// R24 - Shifts of 0, 45, 90 or 135 degrees, multiples of 45.
// R25 - Loop reset restarts counter; lock stays low until wait elapses.
`include "rsps_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rsps_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic ref_clk_pin,
  input wire logic user_clk_pin,
  input wire logic dll_reset_pin,
  input wire logic dll_reset_core,
  input wire rsps_pkg::rsps_dll_cfg_s dll_cfg,
  input wire rsps_pkg::rsps_set_t core_delay_setting,
  input wire rsps_pkg::rsps_set_t phase_offset,
  input wire logic [`RSPS_NSTROBE-1:0] strobe_pin,
  input wire rsps_pkg::rsps_strobe_cfg_s [`RSPS_NSTROBE-1:0] strobe_cfg,
  input wire logic [`RSPS_NGROUP-1:0][2:0] tap_sel,
  output rsps_pkg::rsps_set_t loop_setting,
  output rsps_pkg::rsps_set_t delay_setting,
  output rsps_pkg::rsps_set_t offset_setting,
  output logic dll_locked,
  output logic phase_up,
  output logic update_enable,
  output logic [`RSPS_NSTROBE-1:0] shifted_strobe,
  output logic [`RSPS_NSTROBE-1:0] gate_enable,
  output logic [`RSPS_NGROUP-1:0] level_clk
);

  localparam int NS = `RSPS_NSTROBE;
  localparam int NG = `RSPS_NGROUP;
  localparam int NE = `RSPS_STROBE_ELEMS;
  localparam int NL = `RSPS_DLL_ELEMS;

  // Synchroniser stages and edge history
  logic [`RSPS_NSYNC-1:0] sync_a;
  logic [`RSPS_NSYNC-1:0] sync_b;
  logic [`RSPS_NSYNC-1:0] sync_q;
  logic ref_s;
  logic ref_rise;
  logic user_rise;
  logic rst_pin_s;
  logic [NS-1:0] strobe_s;

  // Loop state
  rsps_pkg::rsps_lock_e lock_state;
  logic [`RSPS_LOCK_W-1:0] lock_cnt;
  logic [`RSPS_LOCK_W-1:0] lock_target;
  logic loop_reset;
  logic loop_step;
  rsps_pkg::rsps_set_t loop_bin;
  logic [NL-1:0] loop_tap;

  // Update enable
  logic [2:0] upd_cnt;
  logic upd_edge;

  // Registered settings and their binary forms
  rsps_pkg::rsps_set_t src_gray;
  rsps_pkg::rsps_set_t set_bin;
  rsps_pkg::rsps_set_t first_bin;
  logic [`RSPS_SET_W:0] offset_sum;

  // Strobe chains and gating
  logic [NS-1:0][NE-1:0] chain_tap;
  logic [NS-1:0] raw_strobe;
  logic [NS-1:0] raw_q;
  logic [NS-1:0] hr_stage;
  logic [NS-1:0] post_reg;
  logic [NS-1:0] gate_stage;
  logic [NS-1:0] gate_comb;
  logic hr_phase;

  // Two flip-flops on every pin, third stage for edge history
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_q <= '0;
    end else begin
      sync_a <= {strobe_pin, user_clk_pin, dll_reset_pin, ref_clk_pin};
      sync_b <= sync_a;
      sync_q <= sync_b;
    end
  end

  assign ref_s = sync_b[0];
  assign rst_pin_s = sync_b[1];
  assign ref_rise = sync_b[0] & ~sync_q[0];
  assign user_rise = sync_b[2] & ~sync_q[2];
  assign strobe_s = sync_b[`RSPS_NSYNC-1:3];

  // Loop reset from core logic or from the pin
  assign loop_reset = dll_reset_core | rst_pin_s;

  // Lock wait chosen by jitter mode
  assign lock_target = dll_cfg.low_jitter ? `RSPS_LOCK_LOWJIT
                                          : `RSPS_LOCK_NORMAL;

  // Lock sequence counted in reference cycles
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_state <= rsps_pkg::DLL_RESET;
      lock_cnt <= '0;
    end else if (loop_reset) begin
      lock_state <= rsps_pkg::DLL_RESET; // [R25]
      lock_cnt <= '0;
    end else begin
      case (lock_state)
        rsps_pkg::DLL_RESET: begin
          lock_state <= rsps_pkg::DLL_WAIT;
          lock_cnt <= '0;
        end
        rsps_pkg::DLL_WAIT: begin
          if (ref_rise) begin
            if (lock_cnt == lock_target - 12'h001) begin
              lock_state <= rsps_pkg::DLL_LOCKED; // [R03]
            end
            lock_cnt <= lock_cnt + 12'h001;
          end
        end
        rsps_pkg::DLL_LOCKED: begin
          lock_cnt <= lock_cnt;
        end
        default: begin
          lock_state <= rsps_pkg::DLL_RESET;
        end
      endcase
    end
  end

  // Lock indication held low through the wait
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dll_locked <= 1'b0;
    end else begin
      dll_locked <= !loop_reset &&
                    lock_state == rsps_pkg::DLL_LOCKED; // [R25]
    end
  end

  // Loop chain of eight elements, each tap worth 45 degrees at lock
  assign loop_bin = rsps_pkg::gray2bin(loop_setting);
  genvar gl;
  generate
    for (gl = 0; gl < NL; gl++) begin : g_loop
      rsps_dly_elem u_elem (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sig_in(gl == 0 ? ref_s : loop_tap[(gl == 0) ? 0 : gl - 1]),
        .steps(loop_bin),
        .sig_out(loop_tap[gl])
      ); // [R01] [R22]
    end
  endgenerate

  // Phase comparator: chain output still high means delay too short
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_up <= 1'b0;
    end else if (ref_rise) begin
      phase_up <= loop_tap[NL-1]; // [R01]
    end
  end

  // Step once per reference edge, after the sample is taken
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_step <= 1'b0;
    end else begin
      loop_step <= ref_rise && !loop_reset &&
                   lock_state != rsps_pkg::DLL_RESET;
    end
  end

  rsps_gray_cnt u_cnt (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(loop_reset),
    .step(loop_step),
    .up(phase_up),
    .gray(loop_setting)
  ); // [R02]

  // Update enable from reference or user clock edges
  assign upd_edge = dll_cfg.update_from_user ? user_rise : ref_rise; // [R08]

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      upd_cnt <= '0;
      update_enable <= 1'b0;
    end else begin
      update_enable <= 1'b0;
      if (upd_edge) begin
        if (upd_cnt == `RSPS_UPD_EDGES - 3'h1) begin
          upd_cnt <= '0;
          update_enable <= 1'b1; // [R08]
        end else begin
          upd_cnt <= upd_cnt + 3'h1;
        end
      end
    end
  end

  // Settings come from the loop or from core logic
  assign src_gray = dll_cfg.use_core_settings ? core_delay_setting
                                              : loop_setting; // [R11] [R12]

  // Settings held until the update enable lets all elements change
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      delay_setting <= `RSPS_DLL_INIT_GRAY;
      offset_setting <= '0;
    end else if (update_enable) begin
      delay_setting <= src_gray; // [R07]
      offset_setting <= phase_offset; // [R07]
    end
  end

  // Binary settings, first element optionally with the offset
  assign set_bin = rsps_pkg::gray2bin(delay_setting);
  assign offset_sum = {1'b0, set_bin} + {1'b0, offset_setting};
  always_comb begin
    first_bin = set_bin;
    if (dll_cfg.offset_enable) begin
      first_bin = offset_sum[`RSPS_SET_W] ? `RSPS_SET_MAX
                                          : offset_sum[`RSPS_SET_W-1:0];
    end // [R10]
  end

  // Half-rate resynchronization enable from a divide-by-two
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hr_phase <= 1'b0;
    end else begin
      hr_phase <= ~hr_phase;
    end
  end

  // One strobe unit per strobe pin
  genvar gs;
  genvar ge;
  generate
    for (gs = 0; gs < NS; gs++) begin : g_strobe
      logic [2:0] want;
      logic [2:0] active;

      // Four matched elements, the pin-side one with its own setting
      for (ge = 0; ge < NE; ge++) begin : g_elem
        rsps_dly_elem u_elem (
          .core_clk(core_clk),
          .reset_n(reset_n),
          .sig_in(ge == 0 ? strobe_s[gs]
                          : chain_tap[gs][(ge == 0) ? 0 : ge - 1]),
          .steps(ge == 0 ? first_bin : set_bin),
          .sig_out(chain_tap[gs][ge])
        ); // [R06] [R09] [R10]
      end

      // Elements in use: one to four, at most three under the loop
      // where each element is 45 degrees; with a doubled or quadrupled
      // loop clock the same limit gives 67.5 or 33.75 degrees
      assign want = {1'b0, strobe_cfg[gs].elem_count} + 3'h1; // [R12]
      assign active = (!dll_cfg.use_core_settings &&
                       want > `RSPS_MAX_LOOP_ELEMS) ?
                      `RSPS_MAX_LOOP_ELEMS : want; // [R24] [R05]

      // Bypass passes the strobe with no shift
      assign raw_strobe[gs] = strobe_cfg[gs].bypass ? strobe_s[gs]
                              : chain_tap[gs][active[1:0] - 2'h1]; // [R14]

      // Optional half-rate first capture of the gate request
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          hr_stage[gs] <= 1'b0;
        end else if (hr_phase) begin
          hr_stage[gs] <= strobe_cfg[gs].gate_req; // [R17]
        end
      end

      assign gate_stage[gs] = strobe_cfg[gs].half_rate_gate ? hr_stage[gs]
                              : strobe_cfg[gs].gate_req; // [R17]

      // Postamble register caught on the shifted strobe falling edge;
      // the preamble low level keeps it from seeing a false edge
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          raw_q[gs] <= 1'b0;
          post_reg[gs] <= 1'b0;
        end else begin
          raw_q[gs] <= raw_strobe[gs];
          if (raw_q[gs] && !raw_strobe[gs]) begin
            post_reg[gs] <= gate_stage[gs]; // [R15] [R16] [R19]
          end
        end
      end

      // AND drops the gate at once, raises it only after the capture
      assign gate_comb[gs] = gate_stage[gs] & post_reg[gs]; // [R18] [R19]

      // Gated strobe toward the data capture registers
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          gate_enable[gs] <= 1'b0;
          shifted_strobe[gs] <= 1'b0;
        end else begin
          gate_enable[gs] <= gate_comb[gs];
          shifted_strobe[gs] <= raw_strobe[gs] & gate_comb[gs]; // [R15]
        end
      end
    end
  endgenerate

  // Leveling: each group picks one loop tap, same compensated settings
  genvar gg;
  generate
    for (gg = 0; gg < NG; gg++) begin : g_level
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          level_clk[gg] <= 1'b0;
        end else begin
          level_clk[gg] <= loop_tap[tap_sel[gg]]; // [R21] [R23]
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [verilog/rsps_top_note_unused.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [tb/rsps_top_chk.sv]
/*
  Port checker of rsps_top: lock wait, Gray stepping, update enable,
  registered settings, gating and tap selection.
  Assumes binding onto rsps_top and rsps_cfg.svh on the include path.
*/
`include "rsps_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rsps_top_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic ref_clk_pin,
  input wire logic dll_reset_pin,
  input wire logic dll_reset_core,
  input wire rsps_pkg::rsps_dll_cfg_s dll_cfg,
  input wire rsps_pkg::rsps_set_t core_delay_setting,
  input wire rsps_pkg::rsps_set_t phase_offset,
  input wire rsps_pkg::rsps_strobe_cfg_s [`RSPS_NSTROBE-1:0] strobe_cfg,
  input wire logic [`RSPS_NGROUP-1:0][2:0] tap_sel,
  input wire rsps_pkg::rsps_set_t loop_setting,
  input wire rsps_pkg::rsps_set_t delay_setting,
  input wire rsps_pkg::rsps_set_t offset_setting,
  input wire logic dll_locked,
  input wire logic update_enable,
  input wire logic [`RSPS_NSTROBE-1:0] shifted_strobe,
  input wire logic [`RSPS_NSTROBE-1:0] gate_enable,
  input wire logic [`RSPS_NGROUP-1:0] level_clk
);
  logic ref_q;
  logic [11:0] ref_cnt;
  logic [11:0] need;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Lock wait for the selected mode
  assign need = dll_cfg.low_jitter ? `RSPS_LOCK_LOWJIT : `RSPS_LOCK_NORMAL;

  // Reference rises since the last loop reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_q <= 1'b0;
      ref_cnt <= 12'h000;
    end else begin
      ref_q <= ref_clk_pin;
      if (dll_reset_core || dll_reset_pin) ref_cnt <= 12'h000;
      else if (ref_clk_pin && !ref_q && ref_cnt != 12'hFFF)
        ref_cnt <= ref_cnt + 12'h001;
    end
  end

  AST_LOCK_WAIT: assert property ($rose(dll_locked) |->
    ref_cnt >= need && ref_cnt <= need + 12'h001)
    else $error("lock after wrong reference count");
  AST_LOOP_RESET: assert property (dll_reset_core |=>
    !dll_locked && loop_setting == `RSPS_DLL_INIT_GRAY)
    else $error("loop reset did not restart the loop");
  AST_GRAY_STEP: assert property ($changed(loop_setting) &&
    loop_setting != `RSPS_DLL_INIT_GRAY |->
    $countones(loop_setting ^ $past(loop_setting)) == 1)
    else $error("loop setting moved by more than one Gray step");
  AST_UPD_PULSE: assert property (update_enable |=>
    !update_enable [*3])
    else $error("update enable longer than one pulse");
  AST_SET_HOLD: assert property ($changed(delay_setting) ||
    $changed(offset_setting) |-> $past(update_enable))
    else $error("settings changed without update enable");
  AST_SET_LOAD: assert property (update_enable |=>
    offset_setting == $past(phase_offset) &&
    delay_setting == ($past(dll_cfg.use_core_settings) ?
    $past(core_delay_setting) : $past(loop_setting)))
    else $error("settings not loaded from selected source");
  AST_GATE_FORCE: assert property (
    (shifted_strobe & ~gate_enable) == '0)
    else $error("shifted strobe high with gate closed");
  AST_GATE_DROP: assert property (!strobe_cfg[0].half_rate_gate &&
    !strobe_cfg[0].gate_req |=> !gate_enable[0])
    else $error("gate did not close at once");
  AST_GATE_RISE: assert property ($rose(gate_enable[0]) &&
    !$past(strobe_cfg[0].half_rate_gate) |-> $past(strobe_cfg[0].gate_req))
    else $error("gate opened without request");
  AST_HALF_RATE: assert property (strobe_cfg[0].half_rate_gate &&
    !strobe_cfg[0].gate_req [*2] |=> ##1 !gate_enable[0])
    else $error("half-rate stage kept the gate open");
  AST_LEVEL_MATCH: assert property (tap_sel[0] == tap_sel[1] |=>
    level_clk[0] == level_clk[1])
    else $error("groups on one tap differ");
endmodule

bind rsps_top rsps_top_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .ref_clk_pin(ref_clk_pin), .dll_reset_pin(dll_reset_pin),
  .dll_reset_core(dll_reset_core), .dll_cfg(dll_cfg),
  .core_delay_setting(core_delay_setting), .phase_offset(phase_offset),
  .strobe_cfg(strobe_cfg), .tap_sel(tap_sel), .loop_setting(loop_setting),
  .delay_setting(delay_setting), .offset_setting(offset_setting),
  .dll_locked(dll_locked), .update_enable(update_enable),
  .shifted_strobe(shifted_strobe), .gate_enable(gate_enable),
  .level_clk(level_clk));

`default_nettype wire

// [tb/rsps_mem_strobe.sv]
/*
  Memory side strobe model: released line between bursts, low preamble,
  three strobe pulses, low postamble.
  Assumes burst_req is held one core_clk cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module rsps_mem_strobe (
  input wire logic core_clk,
  input wire logic burst_req,
  output logic strobe_out,
  output logic probe,
  output logic busy
);
  // Burst sequencer, released line toggles as it has no pull
  initial begin
    strobe_out = 1'b0;
    probe = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge core_clk);
      if (burst_req !== 1'b1) strobe_out <= #1 ~strobe_out;
      else begin
        busy <= #1 1'b1;
        strobe_out <= #1 1'b0;
        repeat (30) @(posedge core_clk);
        for (int i = 0; i < 3; i++) begin
          strobe_out <= #1 1'b1;
          probe <= #1 (i == 1);
          repeat (30) @(posedge core_clk);
          strobe_out <= #1 1'b0;
          probe <= #1 1'b0;
          repeat (30) @(posedge core_clk);
        end
        busy <= #1 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// [tb/rsps_top_tb.sv]
/*
  Testbench of rsps_top: lock waits, taps, update enable, strobe delay,
  bypass, offset and gating.
  Assumes the strobe model and the bound checker are compiled with it.
*/
`include "rsps_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rsps_top_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ref_clk_pin = 1'b0;
  logic user_clk_pin = 1'b0;
  logic dll_reset_pin = 1'b0;
  logic dll_reset_core = 1'b0;
  logic burst_req = 1'b0;
  logic [3:0] div = 4'h0;
  rsps_pkg::rsps_dll_cfg_s dll_cfg = '0;
  rsps_pkg::rsps_set_t core_delay_setting = 7'h00;
  rsps_pkg::rsps_set_t phase_offset = 7'h00;
  rsps_pkg::rsps_strobe_cfg_s [`RSPS_NSTROBE-1:0] strobe_cfg = '0;
  logic [`RSPS_NGROUP-1:0][2:0] tap_sel = '0;
  logic mem_strobe, probe, mem_busy, dll_locked, phase_up, update_enable;
  rsps_pkg::rsps_set_t loop_setting, delay_setting, offset_setting;
  logic [`RSPS_NSTROBE-1:0] strobe_pin, shifted_strobe, gate_enable;
  logic [`RSPS_NGROUP-1:0] level_clk;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int upd_cnt = 0;
  int ref_rises = 0;

  // Both strobe pins see the same memory strobe
  assign strobe_pin = {`RSPS_NSTROBE{mem_strobe}};
  always #10 core_clk = ~core_clk;

  // Reference of 16 core cycles, moved just after the edge
  always @(posedge core_clk) begin
    div <= div + 4'h1;
    if (div[2:0] == 3'h7) ref_clk_pin <= #1 ~ref_clk_pin;
  end
  always @(posedge ref_clk_pin) ref_rises++;

  // Update pulse count and run limit
  always @(posedge core_clk) begin
    cyc++;
    if (update_enable === 1'b1) upd_cnt++;
    if (cyc == 90000) begin
      err_total++;
      summarize();
    end
  end

  rsps_mem_strobe MEM (.core_clk(core_clk), .burst_req(burst_req),
    .strobe_out(mem_strobe), .probe(probe), .busy(mem_busy));

  rsps_top DUT (.core_clk(core_clk), .reset_n(reset_n),
    .ref_clk_pin(ref_clk_pin), .user_clk_pin(user_clk_pin),
    .dll_reset_pin(dll_reset_pin), .dll_reset_core(dll_reset_core),
    .dll_cfg(dll_cfg), .core_delay_setting(core_delay_setting),
    .phase_offset(phase_offset), .strobe_pin(strobe_pin),
    .strobe_cfg(strobe_cfg), .tap_sel(tap_sel),
    .loop_setting(loop_setting), .delay_setting(delay_setting),
    .offset_setting(offset_setting), .dll_locked(dll_locked),
    .phase_up(phase_up), .update_enable(update_enable),
    .shifted_strobe(shifted_strobe), .gate_enable(gate_enable),
    .level_clk(level_clk));

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Loop reset from pin or core, then wait for lock
  task automatic lock_run(input logic pin, input logic lj, input int need);
    int r0;
    int i;
    dll_cfg.low_jitter = lj;
    dll_reset_pin = pin;
    dll_reset_core = ~pin;
    // Release well after a reference rise, so no rise straddles it
    @(posedge ref_clk_pin);
    tick(4);
    chk(dll_locked, 1'b0);
    chk(loop_setting, `RSPS_DLL_INIT_GRAY);
    dll_reset_pin = 1'b0;
    dll_reset_core = 1'b0;
    r0 = ref_rises;
    for (i = 0; i < 50000 && dll_locked !== 1'b1; i++) tick(1);
    chk(ref_rises - r0 >= need && ref_rises - r0 <= need + 1, 1'b1);
  endtask

  // Sixteen source edges give four update pulses
  task automatic upd_count(input logic user);
    int c0;
    dll_cfg.update_from_user = user;
    @(posedge ref_clk_pin);
    tick(10);
    c0 = upd_cnt;
    for (int i = 0; i < 16; i++) begin
      if (user) begin
        user_clk_pin = 1'b1;
        tick(8);
        user_clk_pin = 1'b0;
        tick(8);
      end else begin
        @(posedge ref_clk_pin);
      end
    end
    tick(10);
    chk(upd_cnt - c0, 4);
  endtask

  // One burst; delay of the second strobe pulse, then gate closing
  task automatic strobe_case(input logic byp, input logic [1:0] ec,
      input logic off, input logic hr, input int exp);
    int d;
    d = 0;
    strobe_cfg[0] = {byp, ec, hr, 1'b1};
    strobe_cfg[1] = {byp, ec, hr, 1'b0};
    dll_cfg.offset_enable = off;
    burst_req = 1'b1;
    tick(1);
    burst_req = 1'b0;
    @(posedge probe);
    while (shifted_strobe[0] !== 1'b1 && d < 60) begin
      tick(1);
      d++;
    end
    chk(d, exp);
    chk(shifted_strobe[1], 1'b0);
    for (d = 0; d < 400 && mem_busy === 1'b1; d++) tick(1);
    strobe_cfg[0].gate_req = 1'b0;
    tick(3);
    chk(gate_enable, 2'b00);
    tick(30);
    chk(shifted_strobe, 2'b00);
  endtask

  initial begin
    tick(8);
    chk(loop_setting, `RSPS_DLL_INIT_GRAY);
    chk(delay_setting, `RSPS_DLL_INIT_GRAY);
    chk({phase_up, dll_locked, update_enable, gate_enable}, 5'h00);
    reset_n = 1'b1;
    tick(4);
    lock_run(1'b0, 1'b0, `RSPS_LOCK_NORMAL);
    for (int t = 0; t < 8; t++) begin
      logic [1:0] hi;
      logic [1:0] lo;
      hi = 2'b00;
      lo = 2'b00;
      tap_sel = {2{3'(t)}};
      tick(2);
      for (int i = 0; i < 40; i++) begin
        hi = hi | level_clk;
        lo = lo | ~level_clk;
        tick(1);
      end
      chk({hi, lo}, 4'hF);
    end
    upd_count(1'b0);
    upd_count(1'b1);
    dll_cfg.update_from_user = 1'b0;
    dll_cfg.use_core_settings = 1'b1;
    core_delay_setting = 7'h03;
    phase_offset = 7'h01;
    tick(200);
    chk(delay_setting, 7'h03);
    chk(offset_setting, 7'h01);
    strobe_case(1'b1, 2'h0, 1'b0, 1'b0, 3);
    for (int e = 0; e < 4; e++)
      strobe_case(1'b0, 2'(e), 1'b0, 1'b0, 7 + 4 * e);
    strobe_case(1'b0, 2'h0, 1'b1, 1'b0, 8);
    strobe_case(1'b1, 2'h0, 1'b0, 1'b1, 3);
    lock_run(1'b1, 1'b1, `RSPS_LOCK_LOWJIT);
    summarize();
  end
endmodule

`default_nettype wire
